// [tec_channel.sv]
/*
 * One 8-bit count/compare channel. CHAN selects the clock table:
 * 0 and 1 may count event edges, 2 counts only prescaled clocks.
 * Assumes the event input is synchronous to the system clock.
 */
`timescale 1ns/1ns
module tec_channel
    import tec_pkg::*;
#(
    parameter int unsigned CHAN = 0
) (
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    tec_tick_if.snk         ticks,
    input  wire logic [7:0] ctrl_in,
    input  wire logic [7:0] compare_in,
    input  wire logic       event_in,
    output logic      [7:0] count_out,
    output logic            match_out
);
    logic       event_prev;
    logic       count_en;
    logic       run;
    logic [1:0] clksel;

    assign run    = ctrl_in[CTRL_RUN_BIT];
    assign clksel = ctrl_in[CTRL_CLKSEL_HI:CTRL_CLKSEL_LO];

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            event_prev <= 1'b0;
        end else begin
            event_prev <= event_in;
        end
    end

    always_comb begin
        count_en = 1'b0;
        if (CHAN == 0) begin
            unique case (clksel)
                CLKSEL_00: count_en = ticks.tick[TAP_DIV64];
                CLKSEL_01: count_en = ticks.tick[TAP_DIV512];
                CLKSEL_10: count_en = event_in & ~event_prev;
                CLKSEL_11: count_en = ~event_in & event_prev;
            endcase
        end else if (CHAN == 1) begin
            unique case (clksel)
                CLKSEL_00: count_en = ticks.tick[TAP_DIV16];
                CLKSEL_01: count_en = ticks.tick[TAP_DIV256];
                CLKSEL_10: count_en = event_in & ~event_prev;
                CLKSEL_11: count_en = ~event_in & event_prev;
            endcase
        end else begin
            unique case (clksel)
                CLKSEL_00: count_en = ticks.tick[TAP_DIV8];
                CLKSEL_01: count_en = ticks.tick[TAP_DIV128];
                CLKSEL_10: count_en = ticks.tick[TAP_DIV1024];
                CLKSEL_11: count_en = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            count_out <= COUNT_RESET;
            match_out <= 1'b0;
        end else if (!run) begin
            count_out <= COUNT_RESET;
            match_out <= 1'b0;
        end else if (count_en) begin
            if (count_out == compare_in) begin
                count_out <= COUNT_RESET;
                match_out <= 1'b1;
            end else begin
                count_out <= count_out + 8'h01;
                match_out <= 1'b0;
            end
        end else begin
            match_out <= 1'b0;
        end
    end
endmodule

// [tec_pkg.sv]
/*
 * Package for the triple 8-bit timer/event counter: register addresses,
 * control field positions, reset values and prescaler tap indices.
 * Assumes a single 100 MHz system clock and byte-wide register access.
 */
package tec_pkg;

    localparam int unsigned  SYS_CLK_FREQ_HZ = 100_000_000;

    // register addresses
    localparam logic [15:0]  ADDR_CHAN0_COMPARE = 16'hff50;
    localparam logic [15:0]  ADDR_CHAN0_COUNT   = 16'hff51;
    localparam logic [15:0]  ADDR_CHAN0_CONTROL = 16'hff53;
    localparam logic [15:0]  ADDR_CHAN1_COMPARE = 16'hff54;
    localparam logic [15:0]  ADDR_CHAN1_COUNT   = 16'hff55;
    localparam logic [15:0]  ADDR_CHAN1_CONTROL = 16'hff57;
    localparam logic [15:0]  ADDR_CHAN2_COMPARE = 16'hff58;
    localparam logic [15:0]  ADDR_CHAN2_COUNT   = 16'hff59;
    localparam logic [15:0]  ADDR_CHAN2_CONTROL = 16'hff5b;

    // control field positions
    localparam int unsigned  CTRL_RUN_BIT      = 7;
    localparam int unsigned  CTRL_CLKSEL_HI    = 2;
    localparam int unsigned  CTRL_CLKSEL_LO    = 1;
    localparam int unsigned  CTRL_OUT_EN_BIT   = 0;

    // bits that hold state; all others read as zero
    localparam logic [7:0]   CTRL01_KEEP_MASK  = 8'h86;
    localparam logic [7:0]   CTRL2_KEEP_MASK   = 8'h87;

    localparam logic [7:0]   CTRL_RESET        = 8'h00;
    localparam logic [7:0]   COUNT_RESET       = 8'h00;
    localparam logic [9:0]   PRESCALE_RESET    = 10'h000;

    // prescaler tap indices: divide by 2**(3..10 as listed)
    localparam int unsigned  TAP_DIV8    = 0;
    localparam int unsigned  TAP_DIV16   = 1;
    localparam int unsigned  TAP_DIV64   = 2;
    localparam int unsigned  TAP_DIV128  = 3;
    localparam int unsigned  TAP_DIV256  = 4;
    localparam int unsigned  TAP_DIV512  = 5;
    localparam int unsigned  TAP_DIV1024 = 6;
    localparam int unsigned  TAP_COUNT   = 7;

    localparam logic [1:0]   CLKSEL_00 = 2'h0;
    localparam logic [1:0]   CLKSEL_01 = 2'h1;
    localparam logic [1:0]   CLKSEL_10 = 2'h2;
    localparam logic [1:0]   CLKSEL_11 = 2'h3;

    // merge a masked write into a control byte
    function automatic logic [7:0] tec_merge(input logic [7:0] old_val,
                                             input logic [7:0] wdata,
                                             input logic [7:0] wmask,
                                             input logic [7:0] keep);
        tec_merge = ((old_val & ~wmask) | (wdata & wmask)) & keep;
    endfunction

endpackage

// [tec_prescaler.sv]
/*
 * Free-running prescaler giving one-cycle enable pulses at the system
 * clock divided by 8, 16, 64, 128, 256, 512 and 1024.
 * Assumes a synchronous active-low reset.
 */
`timescale 1ns/1ns
module tec_prescaler
    import tec_pkg::*;
(
    input  wire logic    clock_in,
    input  wire logic    nrst_in,
    tec_tick_if.src      ticks
);
    logic [9:0] div_cnt;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            div_cnt <= PRESCALE_RESET;
        end else begin
            div_cnt <= div_cnt + 10'h001;
        end
    end

    // a tap fires when the low bits of the divider are all ones
    always_comb begin
        ticks.tick[TAP_DIV8]    = &div_cnt[2:0];
        ticks.tick[TAP_DIV16]   = &div_cnt[3:0];
        ticks.tick[TAP_DIV64]   = &div_cnt[5:0];
        ticks.tick[TAP_DIV128]  = &div_cnt[6:0];
        ticks.tick[TAP_DIV256]  = &div_cnt[7:0];
        ticks.tick[TAP_DIV512]  = &div_cnt[8:0];
        ticks.tick[TAP_DIV1024] = &div_cnt[9:0];
    end
endmodule

// [tec_pulse_src.sv]
/* tec_pulse_src: far-side pulse source for one event pin.
   Assumes the bench clock; HALF sets cycles per level, so 1 is prompt and 5 slow. */
`timescale 1ns/1ns
module tec_pulse_src #(
    parameter int HALF = 1
) (
    input  wire logic clock_in,
    output logic      level_out
);
    int n = 0;
    initial level_out = 1'b0;
    always @(posedge clock_in) begin
        n <= (n == HALF - 1) ? 0 : n + 1;
        // level moves just after the edge, as a synchronous source would
        if (n == HALF - 1) level_out <= #1 ~level_out;
    end
endmodule

// [tec_tick_if.sv]
/*
 * Interface carrying the prescaler's one-cycle enable pulses.
 * Assumes producer and consumers share the system clock.
 */
`timescale 1ns/1ns
interface tec_tick_if;
    import tec_pkg::*;
    logic [TAP_COUNT-1:0] tick;
    modport src (output tick);
    modport snk (input  tick);
endinterface

// [tec_timer.sv]
/*
 * Top of the triple 8-bit timer/event counter: processor register port,
 * prescaler, three count/compare channels and the channel 2 wave pin.
 * Assumes all inputs are synchronous to clock_in and one access per cycle.
 */
`timescale 1ns/1ns
module tec_timer
    import tec_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    input  wire logic [15:0] bus_addr_in,
    input  wire logic       bus_wr_in,
    input  wire logic [7:0] bus_wmask_in,
    input  wire logic [7:0] bus_wdata_in,
    input  wire logic       bus_rd_in,
    output logic      [7:0] bus_rdata_out,
    output logic            bus_hit_out,
    input  wire logic       chan0_event_in,
    input  wire logic       chan1_event_in,
    output logic      [2:0] chan_match_irq_out,
    output logic            chan2_wave_out
);
    logic [7:0] chan0_ctrl;
    logic [7:0] chan1_ctrl;
    logic [7:0] chan2_ctrl;
    logic [7:0] chan_compare_value [3];
    logic [7:0] chan_counter       [3];
    logic [2:0] chan_match;
    logic [7:0] next_rdata;
    logic       next_hit;

    tec_tick_if ticks ();

    tec_prescaler u_prescaler (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .ticks    (ticks.src)
    );

    // channel 0 and 1 accept event input, channel 2 does not
    tec_channel #(.CHAN(0)) u_chan0 (
        .clock_in   (clock_in),
        .nrst_in    (nrst_in),
        .ticks      (ticks.snk),
        .ctrl_in    (chan0_ctrl),
        .compare_in (chan_compare_value[0]),
        .event_in   (chan0_event_in),
        .count_out  (chan_counter[0]),
        .match_out  (chan_match[0])
    );

    tec_channel #(.CHAN(1)) u_chan1 (
        .clock_in   (clock_in),
        .nrst_in    (nrst_in),
        .ticks      (ticks.snk),
        .ctrl_in    (chan1_ctrl),
        .compare_in (chan_compare_value[1]),
        .event_in   (chan1_event_in),
        .count_out  (chan_counter[1]),
        .match_out  (chan_match[1])
    );

    tec_channel #(.CHAN(2)) u_chan2 (
        .clock_in   (clock_in),
        .nrst_in    (nrst_in),
        .ticks      (ticks.snk),
        .ctrl_in    (chan2_ctrl),
        .compare_in (chan_compare_value[2]),
        .event_in   (1'b0),
        .count_out  (chan_counter[2]),
        .match_out  (chan_match[2])
    );

    // control registers: masked writes give single-bit access
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            chan0_ctrl <= CTRL_RESET;
            chan1_ctrl <= CTRL_RESET;
            chan2_ctrl <= CTRL_RESET;
        end else if (bus_wr_in) begin
            if (bus_addr_in == ADDR_CHAN0_CONTROL) begin
                chan0_ctrl <= tec_merge(chan0_ctrl, bus_wdata_in, bus_wmask_in,
                                        CTRL01_KEEP_MASK);
            end
            if (bus_addr_in == ADDR_CHAN1_CONTROL) begin
                chan1_ctrl <= tec_merge(chan1_ctrl, bus_wdata_in, bus_wmask_in,
                                        CTRL01_KEEP_MASK);
            end
            if (bus_addr_in == ADDR_CHAN2_CONTROL) begin
                chan2_ctrl <= tec_merge(chan2_ctrl, bus_wdata_in, bus_wmask_in,
                                        CTRL2_KEEP_MASK);
            end
        end
    end

    // compare registers: whole-byte writes, no reset value
    always_ff @(posedge clock_in) begin
        if (bus_wr_in) begin
            if (bus_addr_in == ADDR_CHAN0_COMPARE) begin
                chan_compare_value[0] <= bus_wdata_in;
            end
            if (bus_addr_in == ADDR_CHAN1_COMPARE) begin
                chan_compare_value[1] <= bus_wdata_in;
            end
            if (bus_addr_in == ADDR_CHAN2_COMPARE) begin
                chan_compare_value[2] <= bus_wdata_in;
            end
        end
    end

    // read mux; counters are visible but never written
    always_comb begin
        next_rdata = 8'h00;
        next_hit   = 1'b1;
        unique case (bus_addr_in)
            ADDR_CHAN0_COMPARE: next_rdata = chan_compare_value[0];
            ADDR_CHAN0_COUNT:   next_rdata = chan_counter[0];
            ADDR_CHAN0_CONTROL: next_rdata = chan0_ctrl;
            ADDR_CHAN1_COMPARE: next_rdata = chan_compare_value[1];
            ADDR_CHAN1_COUNT:   next_rdata = chan_counter[1];
            ADDR_CHAN1_CONTROL: next_rdata = chan1_ctrl;
            ADDR_CHAN2_COMPARE: next_rdata = chan_compare_value[2];
            ADDR_CHAN2_COUNT:   next_rdata = chan_counter[2];
            ADDR_CHAN2_CONTROL: next_rdata = chan2_ctrl;
            default:            next_hit   = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            bus_rdata_out <= 8'h00;
            bus_hit_out   <= 1'b0;
        end else if (bus_rd_in) begin
            bus_rdata_out <= next_rdata;
            bus_hit_out   <= next_hit;
        end else begin
            bus_hit_out   <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            chan_match_irq_out <= 3'h0;
        end else begin
            chan_match_irq_out <= chan_match;
        end
    end

    // square wave: half-period is one match interval
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            chan2_wave_out <= 1'b0;
        end else if (!chan2_ctrl[CTRL_OUT_EN_BIT]) begin
            chan2_wave_out <= 1'b0;
        end else if (chan_match[2]) begin
            chan2_wave_out <= ~chan2_wave_out;
        end
    end
endmodule

// [tec_timer_sva.sv]
/* tec_timer_sva: port-level checks of tec_timer.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
module tec_timer_sva
    import tec_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        nrst_in,
    input wire logic [15:0] bus_addr_in,
    input wire logic        bus_wr_in,
    input wire logic [7:0]  bus_wmask_in,
    input wire logic [7:0]  bus_wdata_in,
    input wire logic        bus_rd_in,
    input wire logic [7:0]  bus_rdata_out,
    input wire logic        bus_hit_out,
    input wire logic        chan0_event_in,
    input wire logic        chan1_event_in,
    input wire logic [2:0]  chan_match_irq_out,
    input wire logic        chan2_wave_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    wire logic mapped = bus_addr_in inside {[16'hff50:16'hff5b]} && bus_addr_in[1:0] != 2'h2;
    wire logic ctrl01 = bus_addr_in == ADDR_CHAN0_CONTROL || bus_addr_in == ADDR_CHAN1_CONTROL;
    reset_quiet_a: assert property (disable iff (1'b0)
        !nrst_in |=> chan_match_irq_out == 3'h0 && !chan2_wave_out && !bus_hit_out)
        else $error("outputs not quiet after reset");
    mapped_hit_a: assert property (bus_rd_in && mapped |=> bus_hit_out)
        else $error("mapped read without hit");
    unmapped_read_a: assert property (bus_rd_in && !mapped |=>
        !bus_hit_out && bus_rdata_out == 8'h00) else $error("unmapped read answered");
    rsv_zero_a: assert property (bus_rd_in && ctrl01 |=>
        (bus_rdata_out & ~CTRL01_KEEP_MASK) == 8'h00) else $error("reserved bits set");
    ctrl_back_a: assert property (bus_wr_in && ctrl01 && bus_wmask_in == 8'hff
        ##2 bus_rd_in && bus_addr_in == $past(bus_addr_in, 2) |=>
        bus_rdata_out == ($past(bus_wdata_in, 3) & CTRL01_KEEP_MASK))
        else $error("control readback wrong");
    stop_clear_a: assert property (bus_wr_in && bus_addr_in == ADDR_CHAN2_CONTROL
        && bus_wmask_in[7] && !bus_wdata_in[7] ##3 bus_rd_in
        && bus_addr_in == ADDR_CHAN2_COUNT |=> bus_rdata_out == 8'h00)
        else $error("stopped counter not zero");
    ch01_pulse_a: assert property (
        (chan_match_irq_out[1:0] & $past(chan_match_irq_out[1:0])) == 2'h0)
        else $error("match request longer than one cycle");
    ch2_space_a: assert property (chan_match_irq_out[2] |=> !chan_match_irq_out[2] [*7])
        else $error("channel 2 requests closer than 8 cycles");
    wave_cause_a: assert property ($changed(chan2_wave_out) |->
        chan_match_irq_out[2] || !chan2_wave_out) else $error("wave rose without match");
    cover property (chan_match_irq_out[2] && chan2_wave_out);
    cover property (chan_match_irq_out[0]);
    cover property (bus_rd_in && !mapped);
endmodule
bind tec_timer tec_timer_sva chk (.*);

// [tec_timer_tb.sv]
/* tec_timer_tb: self-checking bench for tec_timer: register rows, match
   periods per clock code, then reset and stop cases. Assumes tec_pulse_src. */
`timescale 1ns/1ns
module tec_timer_tb;
    import tec_pkg::*;
    typedef struct {logic [15:0] a; logic [7:0] d, m, e; logic h;} tec_row_t;
    typedef struct {int c; logic [7:0] ctl, cmp; int per;} tec_run_t;
    logic        clock_in = 1'b0, nrst_in = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        ev0, ev1, wave, hit;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wmask = 8'h00, wdata = 8'h00, rdata;
    logic [2:0]  irq;
    int          mismatches = 0, comparisons = 0, n;
    tec_row_t    rows [8] = '{'{16'hff50, 8'h5a, 8'hff, 8'h5a, 1'b1},
        '{16'hff54, 8'h00, 8'hff, 8'h00, 1'b1}, '{16'hff58, 8'hff, 8'hff, 8'hff, 1'b1},
        '{16'hff51, 8'h77, 8'hff, 8'h00, 1'b1}, '{16'hff53, 8'h7f, 8'hff, 8'h06, 1'b1},
        '{16'hff57, 8'hff, 8'h80, 8'h80, 1'b1}, '{16'hff5b, 8'hff, 8'h04, 8'h04, 1'b1},
        '{16'hff52, 8'hff, 8'hff, 8'h00, 1'b0}};
    tec_run_t    runs [13] = '{'{0, 8'h80, 8'h02, 192}, '{0, 8'h82, 8'h00, 512},
        '{0, 8'h84, 8'h04, 10}, '{0, 8'h86, 8'h01, 4}, '{1, 8'h80, 8'hff, 4096},
        '{1, 8'h82, 8'h01, 512}, '{1, 8'h84, 8'h02, 30}, '{1, 8'h86, 8'h00, 10},
        '{2, 8'h81, 8'h03, 32}, '{2, 8'h83, 8'h00, 128}, '{2, 8'h85, 8'h01, 2048},
        '{2, 8'h81, 8'hff, 2048}, '{2, 8'h82, 8'h00, 128}};
    tec_pulse_src #(.HALF(1)) src0 (.clock_in(clock_in), .level_out(ev0));
    tec_pulse_src #(.HALF(5)) src1 (.clock_in(clock_in), .level_out(ev1));
    tec_timer dut (.clock_in(clock_in), .nrst_in(nrst_in), .bus_addr_in(addr),
        .bus_wr_in(wr), .bus_wmask_in(wmask), .bus_wdata_in(wdata), .bus_rd_in(rd),
        .bus_rdata_out(rdata), .bus_hit_out(hit), .chan0_event_in(ev0),
        .chan1_event_in(ev1), .chan_match_irq_out(irq), .chan2_wave_out(wave));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic tally(input bit ok, input string what);
        comparisons++;
        if (!ok) begin
            mismatches++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, exp);
        tally(got === exp, $sformatf("byte %h not %h", got, exp));
    endtask
    task automatic chk_bit(input logic got, exp);
        tally(got === exp, $sformatf("bit %b not %b", got, exp));
    endtask
    task automatic chk_time(input int got, exp);
        tally(got == exp, $sformatf("period %0d not %0d", got, exp));
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d, m);
        @(posedge clock_in) #1;
        addr = a;
        wdata = d;
        wmask = m;
        wr = 1'b1;
        @(posedge clock_in) #1;
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input logic h);
        @(posedge clock_in) #1;
        addr = a;
        rd = 1'b1;
        @(posedge clock_in) #1;
        rd = 1'b0;
        chk_byte(rdata, e);
        chk_bit(hit, h);
    endtask
    task automatic wait_irq(input int c, lim);
        n = 0;
        do begin
            @(posedge clock_in) #1;
            n++;
        end while (irq[c] !== 1'b1 && n < lim);
        if (irq[c] !== 1'b1) tally(1'b0, "no match request");
    endtask
    task automatic run_one(input tec_run_t r);
        logic w;
        wr_reg(ADDR_CHAN0_CONTROL + 16'(4 * r.c), 8'h00, 8'hff);
        wr_reg(ADDR_CHAN0_COMPARE + 16'(4 * r.c), r.cmp, 8'hff);
        wr_reg(ADDR_CHAN0_CONTROL + 16'(4 * r.c), r.ctl, 8'hff);
        wait_irq(r.c, 2 * r.per + 1100);
        w = wave;
        wait_irq(r.c, r.per + 2);
        chk_time(n, r.per);
        if (r.c == 2) chk_bit(wave, r.ctl[0] ? ~w : 1'b0);
        wr_reg(ADDR_CHAN0_CONTROL + 16'(4 * r.c), 8'h00, 8'hff);
    endtask
    initial forever #5 clock_in = ~clock_in;
    initial begin
        repeat (80000) @(posedge clock_in);
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clock_in);
        #1 nrst_in = 1'b1;
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d, rows[i].m);
            rd_chk(rows[i].a, rows[i].e, rows[i].h);
            wr_reg(rows[i].a, 8'h00, 8'hff);
        end
        foreach (runs[i]) run_one(runs[i]);
        wr_reg(ADDR_CHAN2_CONTROL, 8'h81, 8'hff);
        wr_reg(ADDR_CHAN1_CONTROL, 8'h80, 8'hff);
        repeat (50) @(posedge clock_in);
        #1 nrst_in = 1'b0;
        repeat (6) @(posedge clock_in);
        #1 nrst_in = 1'b1;
        chk_bit(wave, 1'b0);
        for (int c = 0; c < 3; c++) begin
            rd_chk(ADDR_CHAN0_CONTROL + 16'(4 * c), 8'h00, 1'b1);
            rd_chk(ADDR_CHAN0_COUNT + 16'(4 * c), 8'h00, 1'b1);
        end
        wr_reg(ADDR_CHAN2_COMPARE, 8'hff, 8'hff);
        wr_reg(ADDR_CHAN2_CONTROL, 8'h80, 8'hff);
        repeat (40) @(posedge clock_in);
        wr_reg(ADDR_CHAN2_CONTROL, 8'h00, 8'h80);
        @(posedge clock_in);
        rd_chk(ADDR_CHAN2_COUNT, 8'h00, 1'b1);
        complete_run();
    end
endmodule
